// *** design/gtc_pkg.sv ***
// shared constants, register layout and carrier types of the gated 16-bit timer/counter core
package gtc_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------------
    localparam logic [31:0] OFF_COUNT_LOW = 32'h0000_0000;
    localparam logic [31:0] OFF_COUNT_HIGH = 32'h0000_0004;
    localparam logic [31:0] OFF_CONTROL = 32'h0000_0008;
    localparam logic [31:0] OFF_STATUS = 32'h0000_000c;
    localparam logic [31:0] OFF_OSC_PINS = 32'h0000_0010;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned STATUS_OVERFLOW_BIT = 0;
    localparam int unsigned PINS_DIR_A_BIT = 0;
    localparam int unsigned PINS_DIR_B_BIT = 1;
    localparam int unsigned PINS_PORT_A_BIT = 2;
    localparam int unsigned PINS_PORT_B_BIT = 3;

    // ------------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------------
    localparam logic [6:0] CONTROL_RESET = 7'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic PIN_DIR_RESET = 1'b1;
    // instruction cycle is the oscillator clock divided by four
    localparam int unsigned INSTR_CYCLE_CLKS = 4;
    localparam logic [1:0] INSTR_DIV_LAST = 2'(INSTR_CYCLE_CLKS - 1);

    // ------------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------------
    // packed from msb: bit 6 down to bit 0 of the control register
    typedef struct packed {
        logic alternate_select;
        logic [1:0] prescale_select;
        logic crystal_osc_enable;
        logic external_sync_disable;
        logic source_select;
        logic timer_on;
    } gtc_ctrl_s;

    // prescale select 00/01/10/11 -> divide by 1/2/4/8
    function automatic logic [2:0] gtc_prescale_mask(input logic [1:0] sel);
        unique case (sel)
            2'h0: gtc_prescale_mask = 3'h0;
            2'h1: gtc_prescale_mask = 3'h1;
            2'h2: gtc_prescale_mask = 3'h3;
            2'h3: gtc_prescale_mask = 3'h7;
        endcase
    endfunction

endpackage

// *** design/gtc_prescale.sv ***
// 2-bit selectable prescaler: passes one of every 1, 2, 4 or 8 count ticks
`timescale 1ns/1ps
module gtc_prescale #(
    parameter int unsigned CNT_W = 3
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // ticks
    input wire logic tick_in,
    input wire logic clear_in,
    input wire logic [1:0] select_in,
    output logic tick_out
);

    typedef struct packed {
        logic [CNT_W-1:0] count;
    } gtc_pre_state_s;

    gtc_pre_state_s state_reg;
    gtc_pre_state_s state_next;
    logic [CNT_W-1:0] mask;

    // ------------------------------------------------------------------
    // divide
    // ------------------------------------------------------------------
    assign mask = CNT_W'(gtc_pkg::gtc_prescale_mask(select_in));
    assign tick_out = tick_in && ((state_reg.count & mask) == mask) && !clear_in;

    always_comb begin
        state_next = state_reg;
        if (clear_in) begin
            state_next.count = '0;
        end else if (tick_in) begin
            state_next.count = (tick_out) ? '0 : state_reg.count + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule

// *** design/gtc_ext_edge.sv ***
// external count clock front end: optional synchroniser, falling-edge arming, rise detect
`timescale 1ns/1ps
module gtc_ext_edge (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // external clock
    input wire logic clock_level_in,
    input wire logic sync_bypass_in,
    input wire logic enable_in,
    // result
    output logic rise_out
);

    typedef struct packed {
        logic async_sample;
        logic sync_first;
        logic sync_second;
        logic prev_level;
        logic armed;
    } gtc_edge_state_s;

    gtc_edge_state_s state_reg;
    gtc_edge_state_s state_next;
    logic level;

    // ------------------------------------------------------------------
    // level selection
    // ------------------------------------------------------------------
    // bypass takes one sample flop only; switching paths may drop or add one edge
    assign level = sync_bypass_in ? state_reg.async_sample : state_reg.sync_second;
    assign rise_out = enable_in && state_reg.armed && level && !state_reg.prev_level;

    always_comb begin
        state_next = state_reg;
        state_next.async_sample = clock_level_in;
        state_next.sync_first = clock_level_in;
        state_next.sync_second = state_reg.sync_first;
        state_next.prev_level = level;
        if (!enable_in) begin
            state_next.armed = 1'b0;
        end else if (!level) begin
            state_next.armed = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule

// *** design/gtc_timer_core.sv ***
// gated 16-bit timer/counter core with an AXI4-Lite register slave
`timescale 1ns/1ps

// Notes on behaviour
// - 16-bit up count read as two bytes; a byte write replaces that byte.
// - source 0 counts Fosc/4 or Fosc by alternate select; source 1 counts pin.
// - internal source advances once per selected clock (Fosc/4 or Fosc) times prescale ratio.
// - external source advances on each rising edge of the pin, after prescaling.
// - sync disable set skips synchronising; clear synchronises to system clock.
// - external counting needs a falling edge seen before the first counted rise.
// - internal oscillator without clock out lets the crystal drive the count.
// - prescaler divides by 1, 2, 4 or 8 per the 2-bit field.
// - prescaler is hidden from software and cleared by any count byte write.
// - oscillator enable starts the crystal; it keeps running during sleep.
// - crystal allowed only with internal or low-power primary oscillator.
// - crystal on forces oscillator pin directions to 1 and port reads to 0.
// - asynchronous counting continues in sleep; overflow flags and wakes.
// - sync/async switching may lose or add one increment; not prevented.
// - prescale code 00=1:1, 01=1:2, 10=1:4, 11=1:8.
// - count rolls from ffff to 0000 and sets the overflow flag.
// - sync disable bit is ignored while the internal source is selected.
module gtc_timer_core (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // axi4-lite write address
    input wire logic [31:0] s_axi_awaddr_in,
    input wire logic [2:0] s_axi_awprot_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // axi4-lite read address
    input wire logic [31:0] s_axi_araddr_in,
    input wire logic [2:0] s_axi_arprot_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // system clocking state
    input wire logic internal_osc_no_clkout_in,
    input wire logic low_power_osc_mode_in,
    input wire logic sleep_in,
    // count clocks
    input wire logic external_count_clock_in,
    input wire logic crystal_clock_in,
    // oscillator pins
    input wire logic osc_pin_a_port_in,
    input wire logic osc_pin_b_port_in,
    output logic osc_pin_a_direction_out,
    output logic osc_pin_b_direction_out,
    // status
    output logic crystal_osc_run_out,
    output logic overflow_flag_out,
    output logic wake_out,
    output logic [15:0] count_out
);

    typedef struct packed {
        // timer
        logic [15:0] count;
        logic overflow_flag;
        gtc_pkg::gtc_ctrl_s ctrl;
        logic osc_pin_a_direction;
        logic osc_pin_b_direction;
        logic [1:0] instr_div;
        logic wake;
        // bus
        logic aw_held;
        logic [31:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } gtc_core_state_s;

    gtc_core_state_s state_reg;
    gtc_core_state_s state_next;

    logic crystal_active;
    logic ext_level;
    logic ext_rise;
    logic instr_tick;
    logic internal_tick;
    logic count_enable;
    logic raw_tick;
    logic count_tick;
    logic aw_fire;
    logic w_fire;
    logic wr_do;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic ar_fire;
    logic count_byte_write;

    // ------------------------------------------------------------------
    // address decode and read view
    // ------------------------------------------------------------------
    function automatic logic gtc_mapped(input logic [31:0] addr);
        gtc_mapped = (addr == gtc_pkg::OFF_COUNT_LOW) || (addr == gtc_pkg::OFF_COUNT_HIGH) ||
            (addr == gtc_pkg::OFF_CONTROL) || (addr == gtc_pkg::OFF_STATUS) ||
            (addr == gtc_pkg::OFF_OSC_PINS);
    endfunction

    function automatic logic [31:0] gtc_read_view(input logic [31:0] addr,
                                                  input gtc_core_state_s st,
                                                  input logic xtal,
                                                  input logic port_a,
                                                  input logic port_b);
        logic [31:0] value;
        value = 32'h0000_0000;
        unique case (addr)
            gtc_pkg::OFF_COUNT_LOW: value[7:0] = st.count[7:0];
            gtc_pkg::OFF_COUNT_HIGH: value[7:0] = st.count[15:8];
            gtc_pkg::OFF_CONTROL: value[6:0] = st.ctrl;
            gtc_pkg::OFF_STATUS: value[gtc_pkg::STATUS_OVERFLOW_BIT] = st.overflow_flag;
            gtc_pkg::OFF_OSC_PINS: begin
                value[gtc_pkg::PINS_DIR_A_BIT] = st.osc_pin_a_direction;
                value[gtc_pkg::PINS_DIR_B_BIT] = st.osc_pin_b_direction;
                value[gtc_pkg::PINS_PORT_A_BIT] = port_a && !xtal;
                value[gtc_pkg::PINS_PORT_B_BIT] = port_b && !xtal;
            end
            default: value = 32'h0000_0000;
        endcase
        gtc_read_view = value;
    endfunction

    // ------------------------------------------------------------------
    // count sources
    // ------------------------------------------------------------------
    assign crystal_active = state_reg.ctrl.crystal_osc_enable &&
        (internal_osc_no_clkout_in || low_power_osc_mode_in);
    // the crystal takes over the pin as count clock once it runs
    assign ext_level = crystal_active ? crystal_clock_in : external_count_clock_in;

    gtc_ext_edge u_ext_edge (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .clock_level_in(ext_level),
        .sync_bypass_in(state_reg.ctrl.external_sync_disable),
        .enable_in(state_reg.ctrl.timer_on && state_reg.ctrl.source_select),
        .rise_out(ext_rise)
    );

    assign instr_tick = (state_reg.instr_div == gtc_pkg::INSTR_DIV_LAST);
    assign internal_tick = state_reg.ctrl.alternate_select ? 1'b1 : instr_tick;
    // sync disable only matters on the external path, so it is not consulted here
    assign raw_tick = state_reg.ctrl.source_select ? ext_rise : internal_tick;
    // in sleep only the unsynchronised external count keeps going
    assign count_enable = state_reg.ctrl.timer_on && (!sleep_in ||
        (state_reg.ctrl.source_select && state_reg.ctrl.external_sync_disable));

    gtc_prescale #(
        .CNT_W(3)
    ) u_prescale (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .tick_in(raw_tick && count_enable),
        .clear_in(count_byte_write),
        .select_in(state_reg.ctrl.prescale_select),
        .tick_out(count_tick)
    );

    // ------------------------------------------------------------------
    // bus handshakes
    // ------------------------------------------------------------------
    assign s_axi_awready_out = !state_reg.aw_held && !state_reg.bvalid;
    assign s_axi_wready_out = !state_reg.w_held && !state_reg.bvalid;
    assign s_axi_arready_out = !state_reg.rvalid;
    assign aw_fire = s_axi_awvalid_in && s_axi_awready_out;
    assign w_fire = s_axi_wvalid_in && s_axi_wready_out;
    assign ar_fire = s_axi_arvalid_in && s_axi_arready_out;
    assign wr_do = (state_reg.aw_held || aw_fire) && (state_reg.w_held || w_fire) &&
        !state_reg.bvalid;
    assign wr_addr = state_reg.aw_held ? state_reg.aw_addr : s_axi_awaddr_in;
    assign wr_data = state_reg.w_held ? state_reg.w_data : s_axi_wdata_in;
    assign wr_strb = state_reg.w_held ? state_reg.w_strb : s_axi_wstrb_in;
    assign count_byte_write = wr_do && wr_strb[0] &&
        ((wr_addr == gtc_pkg::OFF_COUNT_LOW) || (wr_addr == gtc_pkg::OFF_COUNT_HIGH));

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.wake = 1'b0;
        state_next.instr_div = state_reg.instr_div + 2'h1;

        // count and overflow
        if (count_tick) begin
            state_next.count = state_reg.count + 16'h0001;
            if (state_reg.count == gtc_pkg::COUNT_MAX) begin
                state_next.count = gtc_pkg::COUNT_RESET;
                state_next.overflow_flag = 1'b1;
                state_next.wake = sleep_in;
            end
        end

        // bus write channel capture
        if (aw_fire && !wr_do) begin
            state_next.aw_held = 1'b1;
            state_next.aw_addr = s_axi_awaddr_in;
        end
        if (w_fire && !wr_do) begin
            state_next.w_held = 1'b1;
            state_next.w_data = s_axi_wdata_in;
            state_next.w_strb = s_axi_wstrb_in;
        end

        // register write: a byte write beats an increment in the same cycle
        if (wr_do) begin
            state_next.aw_held = 1'b0;
            state_next.w_held = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = gtc_mapped(wr_addr) ? gtc_pkg::RESP_OKAY : gtc_pkg::RESP_SLVERR;
            if (wr_strb[0]) begin
                unique case (wr_addr)
                    gtc_pkg::OFF_COUNT_LOW: begin
                        state_next.count = {state_reg.count[15:8], wr_data[7:0]};
                    end
                    gtc_pkg::OFF_COUNT_HIGH: begin
                        state_next.count = {wr_data[7:0], state_reg.count[7:0]};
                    end
                    gtc_pkg::OFF_CONTROL: state_next.ctrl = wr_data[6:0];
                    gtc_pkg::OFF_STATUS: begin
                        // write one to clear; a same-cycle overflow keeps the flag set
                        if (wr_data[gtc_pkg::STATUS_OVERFLOW_BIT] &&
                            !(count_tick && state_reg.count == gtc_pkg::COUNT_MAX)) begin
                            state_next.overflow_flag = 1'b0;
                        end
                    end
                    gtc_pkg::OFF_OSC_PINS: begin
                        state_next.osc_pin_a_direction = wr_data[gtc_pkg::PINS_DIR_A_BIT];
                        state_next.osc_pin_b_direction = wr_data[gtc_pkg::PINS_DIR_B_BIT];
                    end
                    default: begin
                    end
                endcase
            end
        end
        if (state_reg.bvalid && s_axi_bready_in) begin
            state_next.bvalid = 1'b0;
        end

        // crystal running holds both oscillator pins as inputs
        if (crystal_active) begin
            state_next.osc_pin_a_direction = 1'b1;
            state_next.osc_pin_b_direction = 1'b1;
        end

        // register read
        if (ar_fire) begin
            state_next.rvalid = 1'b1;
            state_next.rdata = gtc_read_view(s_axi_araddr_in, state_reg, crystal_active,
                                             osc_pin_a_port_in, osc_pin_b_port_in);
            state_next.rresp = gtc_mapped(s_axi_araddr_in) ? gtc_pkg::RESP_OKAY :
                gtc_pkg::RESP_SLVERR;
        end else if (state_reg.rvalid && s_axi_rready_in) begin
            state_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_reg <= '0;
            state_reg.count <= gtc_pkg::COUNT_RESET;
            state_reg.ctrl <= gtc_pkg::CONTROL_RESET;
            state_reg.osc_pin_a_direction <= gtc_pkg::PIN_DIR_RESET;
            state_reg.osc_pin_b_direction <= gtc_pkg::PIN_DIR_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign s_axi_bvalid_out = state_reg.bvalid;
    assign s_axi_bresp_out = state_reg.bresp;
    assign s_axi_rvalid_out = state_reg.rvalid;
    assign s_axi_rdata_out = state_reg.rdata;
    assign s_axi_rresp_out = state_reg.rresp;
    // the crystal run request does not look at sleep, so it keeps running
    assign crystal_osc_run_out = crystal_active;
    assign osc_pin_a_direction_out = state_reg.osc_pin_a_direction;
    assign osc_pin_b_direction_out = state_reg.osc_pin_b_direction;
    assign overflow_flag_out = state_reg.overflow_flag;
    assign wake_out = state_reg.wake;
    assign count_out = state_reg.count;

endmodule

// *** sim/gtc_checker.sv ***
// assertions on the timer core's ports
`timescale 1ns/1ps
module gtc_checker (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // register bus
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [31:0] s_axi_rdata_out,
    // clocking state and pins
    input wire logic internal_osc_no_clkout_in,
    input wire logic low_power_osc_mode_in,
    input wire logic sleep_in,
    input wire logic crystal_osc_run_out,
    input wire logic osc_pin_a_direction_out,
    input wire logic osc_pin_b_direction_out,
    // status
    input wire logic overflow_flag_out,
    input wire logic wake_out,
    input wire logic [15:0] count_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_xtal_held;
        crystal_osc_run_out [*2];
    endsequence

    a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
        |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("bvalid lost");
    a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
        |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("rvalid lost");
    a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out
        |=> s_axi_rvalid_out) else $error("no rvalid");
    a_count_step: assert property (
        count_out != $past(count_out) && !$rose(s_axi_bvalid_out)
        |-> count_out == 16'($past(count_out) + 16'h1)) else $error("count jumped");
    a_roll_flag: assert property (
        $past(rst_n_in) && $past(count_out) == 16'hffff && count_out == 16'h0000
        |-> ##[0:1] overflow_flag_out) else $error("no flag");
    a_crystal_gate: assert property (
        crystal_osc_run_out |-> internal_osc_no_clkout_in || low_power_osc_mode_in)
        else $error("bad crystal run");
    a_crystal_pins: assert property (
        s_xtal_held |-> osc_pin_a_direction_out && osc_pin_b_direction_out)
        else $error("pins not inputs");
    a_wake_pulse: assert property (
        wake_out |-> $past(sleep_in) ##1 !wake_out) else $error("bad wake pulse");
endmodule

bind gtc_timer_core gtc_checker gtc_checker_i (.*);

// *** sim/gtc_clock_source.sv ***
// far-side count clocks: pin and crystal
`timescale 1ns/1ps
module gtc_clock_source #(
    parameter real HALF_NS = 7.3
) (
    // control
    input wire logic run_in,
    input wire logic use_crystal_in,
    // clocks
    output logic ext_clk_out,
    output logic xtal_clk_out
);
    logic phase;
    // idles high between bursts, so every rise follows a fall
    initial begin
        phase = 1'b1;
        forever begin
            wait (run_in);
            phase = 1'b0;
            #HALF_NS phase = 1'b1;
            #HALF_NS;
        end
    end
    assign ext_clk_out = use_crystal_in ? 1'b1 : phase;
    assign xtal_clk_out = use_crystal_in ? phase : 1'b1;
endmodule

// *** sim/gtc_timer_core_test.sv ***
// bench for the timer core
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin failures++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module gtc_timer_core_test;
    logic clk_in, rst_n_in, s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
    logic s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in;
    logic s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in, sleep_in, wake_out;
    logic internal_osc_no_clkout_in, low_power_osc_mode_in, external_count_clock_in;
    logic crystal_clock_in, osc_pin_a_port_in, osc_pin_b_port_in, osc_pin_a_direction_out;
    logic osc_pin_b_direction_out, crystal_osc_run_out, overflow_flag_out, run, use_x;
    logic [31:0] s_axi_awaddr_in, s_axi_wdata_in, s_axi_araddr_in, s_axi_rdata_out, rd_q;
    logic [2:0] s_axi_awprot_in, s_axi_arprot_in;
    logic [3:0] s_axi_wstrb_in;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, resp_q;
    logic [15:0] count_out;
    int failures, n_checks, cyc, t_wr, t_rd, edges, wakes, div, exp;
    localparam logic [31:0] LO = gtc_pkg::OFF_COUNT_LOW, HI = gtc_pkg::OFF_COUNT_HIGH;
    localparam logic [31:0] CT = gtc_pkg::OFF_CONTROL, ST = gtc_pkg::OFF_STATUS;
    localparam logic [31:0] PN = gtc_pkg::OFF_OSC_PINS;

    gtc_timer_core gtc_timer_core_i (.*);
    gtc_clock_source gtc_clock_source_i (.run_in(run), .use_crystal_in(use_x),
        .ext_clk_out(external_count_clock_in), .xtal_clk_out(crystal_clock_in));

    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (wake_out) wakes <= wakes + 1;
    end
    always @(posedge (crystal_clock_in & external_count_clock_in)) edges <= edges + 1;

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic limit(input int n);
        if (n >= 100) begin
            failures++;
            $display("ERROR wait expected done seen timeout");
            stop_test();
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        end while (!s_axi_bvalid_out && n < 100);
        s_axi_bready_in <= 1'b0;
        resp_q = s_axi_bresp_out;
        t_wr = cyc;
        limit(n);
    endtask
    task automatic rd(input logic [31:0] a);
        int n;
        @(posedge clk_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
            if (s_axi_arvalid_in && s_axi_arready_out) t_rd = cyc;
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
        end while (!s_axi_rvalid_out && n < 100);
        s_axi_rready_in <= 1'b0;
        rd_q = s_axi_rdata_out;
        resp_q = s_axi_rresp_out;
        limit(n);
    endtask
    task automatic pulses(input int k);
        int n;
        int target;
        target = edges + k;
        @(posedge clk_in);
        run <= 1'b1;
        for (n = 0; edges < target && n < 100; n++) @(posedge clk_in);
        run <= 1'b0;
        repeat (8) @(posedge clk_in);
        limit(n);
    endtask
    task automatic ext(input logic [6:0] c, input logic sl, input logic [15:0] pre, input int k,
                       input logic [15:0] e);
        use_x <= c[3];
        internal_osc_no_clkout_in <= c[3];
        osc_pin_b_port_in <= c[3];
        wr(CT, 32'h0);
        wr(LO, {24'h0, pre[7:0]});
        wr(HI, {24'h0, pre[15:8]});
        if (c[3]) begin
            wr(CT, {25'h0, c[6:1], 1'b0});
            repeat (20) @(posedge clk_in);
            rd(PN);
            `CHK("pins", 32'h3, rd_q);
            `CHK("xrun", 1'b1, crystal_osc_run_out);
        end
        wr(CT, {25'h0, c});
        sleep_in <= sl;
        repeat (10) @(posedge clk_in);
        `CHK("idle", pre, count_out);
        pulses(k);
        sleep_in <= 1'b0;
        `CHK("ext", e, count_out);
    endtask

    initial begin
        {rst_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, sleep_in, run} = '0;
        {s_axi_arvalid_in, s_axi_rready_in, internal_osc_no_clkout_in, use_x} = '0;
        {low_power_osc_mode_in, osc_pin_b_port_in, s_axi_awaddr_in, s_axi_araddr_in} = '0;
        {s_axi_wdata_in, s_axi_awprot_in, s_axi_arprot_in, cyc, edges, wakes} = '0;
        {failures, n_checks, osc_pin_a_port_in, s_axi_wstrb_in} = {64'h0, 1'b1, 4'hf};
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(CT);
        `CHK("ctrl", 32'h0, rd_q);
        rd(PN);
        `CHK("pins", 32'h7, rd_q);
        rd(32'h14);
        `CHK("resp", gtc_pkg::RESP_SLVERR, resp_q);
        wr(32'h14, 32'h0);
        `CHK("bresp", gtc_pkg::RESP_SLVERR, resp_q);
        $display("test reset finished");
        for (int i = 0; i < 8; i++) begin
            div = (i[2] ? 1 : 4) << i[1:0];
            wr(CT, 32'h0);
            wr(LO, 32'h0);
            wr(HI, 32'h0);
            // sync disable set: the internal source ignores it
            wr(CT, {25'h0, i[2], i[1:0], 4'h5});
            repeat (10 * div) @(posedge clk_in);
            rd(LO);
            exp = (t_rd - t_wr) / div;
            `CHK("rate", 1'b1, int'(rd_q[7:0]) + 1 >= exp && int'(rd_q[7:0]) <= exp + 1);
        end
        wr(HI, 32'hff);
        wr(LO, 32'hf0);
        wr(CT, 32'h41);
        repeat (40) @(posedge clk_in);
        wr(CT, 32'h0);
        rd(ST);
        `CHK("flag", 32'h1, rd_q);
        rd(HI);
        `CHK("high", 32'h0, rd_q);
        wr(ST, 32'h1);
        rd(ST);
        `CHK("clear", 32'h0, rd_q);
        wr(HI, 32'h12);
        wr(LO, 32'h34);
        repeat (20) @(posedge clk_in);
        `CHK("held", 16'h1234, count_out);
        $display("test internal finished");
        ext(7'h03, 1'b0, 16'h0, 5, 16'h5);
        ext(7'h13, 1'b0, 16'h0, 6, 16'h3);
        ext(7'h03, 1'b1, 16'h0, 4, 16'h0);
        ext(7'h07, 1'b1, 16'hfffd, 5, 16'h2);
        `CHK("wake", 1, wakes);
        ext(7'h0b, 1'b0, 16'h0, 4, 16'h4);
        ext(7'h33, 1'b0, 16'h0, 6, 16'h0);
        wr(LO, 32'h0);
        pulses(4);
        `CHK("pclr", 16'h0, count_out);
        pulses(4);
        `CHK("pdiv", 16'h1, count_out);
        $display("test external finished");
        stop_test();
    end
endmodule
